// >>> hw/temlo_cfg.svh
// Offsets, field positions, reset values and patterns of the transmitter config bank
`ifndef TEMLO_CFG_SVH
`define TEMLO_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TEMLO_ADDR_POWER   8'h26
`define TEMLO_ADDR_MASK    8'h27
`define TEMLO_ADDR_FORCE   8'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TEMLO_PD_CHAN_RST_BIT  7
`define TEMLO_MASK_DATA_LOSS   0
`define TEMLO_MASK_CLK_LOSS    1
`define TEMLO_MASK_CLK_DETECT  2
`define TEMLO_MASK_FIFO        3
`define TEMLO_MASK_PLL_CLK     4
`define TEMLO_FORCE_HIGH_BIT   0
`define TEMLO_FORCE_LOW_BIT    1

// ----------------------------------------
// Reset values and patterns
// ----------------------------------------
`define TEMLO_PD_RESET     7'h3F
`define TEMLO_PD_NORMAL    7'h3F
`define TEMLO_PD_STANDBY   7'h40
`define TEMLO_MASK_RESET   5'h00
`define TEMLO_FORCE_RESET  2'h0
`define TEMLO_NUM_EVENTS   5
`define TEMLO_CNT_W        8

`endif

// >>> hw/temlo_pkg.sv
// Types shared by the transmitter config bank
package temlo_pkg;

  // ----------------------------------------
  // Register access request
  // ----------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } temlo_req_type;

  // ----------------------------------------
  // Error event strobes, bit order matches the mask register
  // ----------------------------------------
  typedef struct packed {
    logic pll_clk;
    logic fifo;
    logic clk_detect;
    logic clk_loss;
    logic data_loss;
  } temlo_event_type;

endpackage

// >>> hw/temlo_event_counter.sv
// Saturating error event counter with mask and clear
`timescale 1ns/1ps
`default_nettype none

module temlo_event_counter
  import temlo_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clear_in,
  input  wire logic             event_in,
  input  wire logic             mask_in,
  output logic      [CNT_W-1:0] count_out
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_param
    $error("temlo_event_counter: unsupported CNT_W");
  end

  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  // ----------------------------------------
  // Count unmasked events
  // ----------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (clear_in) begin
      count_nxt = '0;
    end else if (event_in && !mask_in && (count_r != {CNT_W{1'b1}})) begin
      count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_out = count_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_count_inc;
    @(posedge clk_in) disable iff (!reset_n_in)
    (event_in && !mask_in && !clear_in && (count_r != {CNT_W{1'b1}}))
      |=> (count_r == $past(count_r) + 1'b1);
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("unmasked event not counted");

endmodule

`default_nettype wire

// >>> hw/temlo_top.sv
// Power-down, event mask and signal loss override register bank
// Behaviour
// - Writing one to bit 7 of the power register pulses a transmit channel reset.
// - The seven-bit power field resets to 3F, and 3F in it means normal operation.
// - Writing 40 to the power field puts the transmitter into low-power standby.
// - Each unmasked error event increments the count of its class until that count saturates at all ones.
// - Counted classes cover FIFO, PLL clock and input clock detect errors, and data and clock signal loss.
// - Mask bit 4 stops PLL clock errors and bit 0 stops data signal loss being counted.
// - Mask bit 3, reset zero, stops FIFO errors being counted.
// - Mask bit 2 stops input clock detect errors being counted.
// - Mask bit 1 stops clock signal loss errors being counted.
// - The override register can fix the signal loss indicator whatever the input does.
// - Override bit 1 drives the indicator low unless bit 0 is set; with both bits clear it follows the input.
// - Override bit 0 drives the indicator high and wins over bit 1.
`timescale 1ns/1ps
`default_nettype none
`include "temlo_cfg.svh"

module temlo_top
  import temlo_pkg::*;
#(
  parameter int NUM_EVENTS = `TEMLO_NUM_EVENTS,
  parameter int CNT_W      = `TEMLO_CNT_W
) (
  input  wire logic                        clk_in,
  input  wire logic                        reset_n_in,
  input  wire temlo_req_type               req_in,
  input  wire temlo_event_type             events_in,
  input  wire logic                        signal_loss_raw_in,
  output logic      [7:0]                  rdata_out,
  output logic                             channel_reset_out,
  output logic      [6:0]                  power_down_out,
  output logic                             standby_out,
  output logic                             signal_loss_indicator_out,
  output logic      [NUM_EVENTS-1:0][CNT_W-1:0] counts_out
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (NUM_EVENTS != `TEMLO_NUM_EVENTS || CNT_W < 1 || CNT_W > 32) begin : g_bad_param
    $error("temlo_top: unsupported NUM_EVENTS or CNT_W");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [6:0]            power_r;
  logic [6:0]            power_nxt;
  logic                  chan_rst_r;
  logic                  chan_rst_nxt;
  logic                  standby_r;
  logic                  standby_nxt;
  logic [4:0]            mask_r;
  logic [4:0]            mask_nxt;
  logic [1:0]            force_r;
  logic [1:0]            force_nxt;
  logic [7:0]            rdata_r;
  logic [7:0]            rdata_nxt;
  logic                  loss_meta_r;
  logic                  loss_sync_r;
  logic                  loss_ind_r;
  logic                  loss_ind_nxt;
  logic [4:0]            event_vec;

  assign event_vec = events_in;

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always_comb begin
    power_nxt    = power_r;
    chan_rst_nxt = 1'b0;
    mask_nxt     = mask_r;
    force_nxt    = force_r;
    rdata_nxt    = rdata_r;
    if (req_in.wr) begin
      if (req_in.addr == `TEMLO_ADDR_POWER) begin
        power_nxt    = req_in.wdata[6:0];
        chan_rst_nxt = req_in.wdata[`TEMLO_PD_CHAN_RST_BIT];
      end else if (req_in.addr == `TEMLO_ADDR_MASK) begin
        mask_nxt = req_in.wdata[4:0];
      end else if (req_in.addr == `TEMLO_ADDR_FORCE) begin
        force_nxt = req_in.wdata[1:0];
      end
    end
    if (req_in.rd) begin
      if (req_in.addr == `TEMLO_ADDR_POWER) begin
        rdata_nxt = {1'b0, power_r};
      end else if (req_in.addr == `TEMLO_ADDR_MASK) begin
        rdata_nxt = {3'h0, mask_r};
      end else if (req_in.addr == `TEMLO_ADDR_FORCE) begin
        rdata_nxt = {6'h00, force_r};
      end else begin
        rdata_nxt = 8'h00;
      end
    end
    standby_nxt = (power_nxt == `TEMLO_PD_STANDBY);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_r    <= `TEMLO_PD_RESET;
      chan_rst_r <= 1'b0;
      standby_r  <= 1'b0;
      mask_r     <= `TEMLO_MASK_RESET;
      force_r    <= `TEMLO_FORCE_RESET;
      rdata_r    <= 8'h00;
    end else begin
      power_r    <= power_nxt;
      chan_rst_r <= chan_rst_nxt;
      standby_r  <= standby_nxt;
      mask_r     <= mask_nxt;
      force_r    <= force_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Signal loss indicator with override
  // ----------------------------------------
  always_comb begin
    if (force_r[`TEMLO_FORCE_HIGH_BIT]) begin
      loss_ind_nxt = 1'b1;
    end else if (force_r[`TEMLO_FORCE_LOW_BIT]) begin
      loss_ind_nxt = 1'b0;
    end else begin
      loss_ind_nxt = loss_sync_r;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      loss_meta_r <= 1'b0;
      loss_sync_r <= 1'b0;
      loss_ind_r  <= 1'b0;
    end else begin
      loss_meta_r <= signal_loss_raw_in;
      loss_sync_r <= loss_meta_r;
      loss_ind_r  <= loss_ind_nxt;
    end
  end

  // ----------------------------------------
  // Error event counters
  // ----------------------------------------
  for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_cnt
    temlo_event_counter #(
      .CNT_W      (CNT_W)
    ) temlo_event_counter_inst (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .clear_in   (chan_rst_r),
      .event_in   (event_vec[i]),
      .mask_in    (mask_r[i]),
      .count_out  (counts_out[i])
    );
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_out                 = rdata_r;
  assign channel_reset_out         = chan_rst_r;
  assign power_down_out            = power_r;
  assign standby_out               = standby_r;
  assign signal_loss_indicator_out = loss_ind_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_chan_rst;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_in.wr && req_in.addr == `TEMLO_ADDR_POWER && req_in.wdata[7])
      |=> channel_reset_out;
  endproperty
  a_chan_rst: assert property (p_chan_rst)
    else $error("channel reset not pulsed");

  property p_chan_rst_cause;
    @(posedge clk_in) disable iff (!reset_n_in)
    channel_reset_out |-> $past(req_in.wr && req_in.addr == `TEMLO_ADDR_POWER
                                && req_in.wdata[7]);
  endproperty
  a_chan_rst_cause: assert property (p_chan_rst_cause)
    else $error("channel reset without write");

  property p_power_write;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_in.wr && req_in.addr == `TEMLO_ADDR_POWER)
      |=> (power_down_out == $past(req_in.wdata[6:0]));
  endproperty
  a_power_write: assert property (p_power_write)
    else $error("power field not written");

  property p_standby;
    @(posedge clk_in) disable iff (!reset_n_in)
    standby_out == (power_down_out == 7'h40);
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby does not match power field");

  for (genvar j = 0; j < NUM_EVENTS; j++) begin : g_chk
    property p_mask_hold;
      @(posedge clk_in) disable iff (!reset_n_in)
      (mask_r[j] && !chan_rst_r) |=> $stable(counts_out[j]);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
      else $error("masked class was counted");
  end

  property p_force_high;
    @(posedge clk_in) disable iff (!reset_n_in)
    force_r[0] |=> signal_loss_indicator_out;
  endproperty
  a_force_high: assert property (p_force_high)
    else $error("indicator not forced high");

  property p_force_low;
    @(posedge clk_in) disable iff (!reset_n_in)
    (force_r == 2'h2) |=> !signal_loss_indicator_out;
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("indicator not forced low");

  property p_loss_follow;
    @(posedge clk_in) disable iff (!reset_n_in)
    (force_r == 2'h0) |=> (signal_loss_indicator_out == $past(loss_sync_r));
  endproperty
  a_loss_follow: assert property (p_loss_follow)
    else $error("indicator does not follow input");

  property p_mask_read;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_in.rd && req_in.addr == `TEMLO_ADDR_MASK) |=> (rdata_out == {3'h0, $past(mask_r)});
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask readback wrong");

  c_standby: cover property (@(posedge clk_in) disable iff (!reset_n_in) $rose(standby_out));
  c_chan_rst: cover property (@(posedge clk_in) disable iff (!reset_n_in) channel_reset_out);
  c_both_force: cover property (@(posedge clk_in) disable iff (!reset_n_in)
                                (force_r == 2'h3) ##1 signal_loss_indicator_out);
  c_fifo_masked: cover property (@(posedge clk_in) disable iff (!reset_n_in)
                                 events_in.fifo && mask_r[3]);

endmodule

`default_nettype wire

// >>> verif/temlo_host_model.sv
// Host controller model issuing register requests to the config bank
`timescale 1ns/1ps
`default_nettype none
`include "temlo_cfg.svh"

module temlo_host_model
  import temlo_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output var temlo_req_type req_out
);
  initial req_out = '0;

  // Released address and data show their inverse
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    access(1'b0, a, 8'h00);
    @(posedge clk_in);
    d = rdata_in;
  endtask

  task automatic set_normal();
    write_reg(`TEMLO_ADDR_POWER, 8'h3F);
  endtask

  task automatic set_standby();
    write_reg(`TEMLO_ADDR_POWER, 8'h40);
  endtask

  // Channel reset keeps the power field at normal
  task automatic chan_reset();
    write_reg(`TEMLO_ADDR_POWER, 8'hBF);
  endtask
endmodule

`default_nettype wire

// >>> verif/tx_event_mask_los_override_test.sv
// Self-checking bench of the transmitter config bank
`timescale 1ns/1ps
`default_nettype none
`include "temlo_cfg.svh"

module tx_event_mask_los_override_test
  import temlo_pkg::*;
  ;
  logic            clk_in = 1'b0;
  logic            reset_n_in = 1'b0;
  temlo_req_type   req;
  temlo_event_type events = '0;
  logic            raw = 1'b0;
  logic [7:0]      rdata;
  logic            chan_rst;
  logic [6:0]      pd;
  logic            standby;
  logic            ind;
  logic [4:0][7:0] counts;
  logic [7:0]      rd;
  int              error_cnt = 0;
  int              checks_done = 0;
  int              cycles = 0;

  always #2 clk_in = ~clk_in;

  temlo_host_model temlo_host_model_inst (
    .clk_in   (clk_in),
    .rdata_in (rdata),
    .req_out  (req)
  );

  temlo_top temlo_top_inst (
    .clk_in                    (clk_in),
    .reset_n_in                (reset_n_in),
    .req_in                    (req),
    .events_in                 (events),
    .signal_loss_raw_in        (raw),
    .rdata_out                 (rdata),
    .channel_reset_out         (chan_rst),
    .power_down_out            (pd),
    .standby_out               (standby),
    .signal_loss_indicator_out (ind),
    .counts_out                (counts)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    temlo_host_model_inst.read_reg(a, rd);
    check(n, rd, e);
  endtask

  task automatic pulse(input temlo_event_type v, input int n);
    @(posedge clk_in);
    events <= v;
    repeat (n) @(posedge clk_in);
    events <= '0;
    #1;
  endtask

  task automatic frc(input logic [7:0] a, input logic [7:0] v, input logic e);
    temlo_host_model_inst.write_reg(a, v);
    tick(2);
    check("indicator", 8'(ind), 8'(e));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("power_down", 8'(pd), 8'h3F);
    check("standby", 8'(standby), 8'h00);
    rd_chk("power reg", `TEMLO_ADDR_POWER, 8'h3F);
    rd_chk("mask reg", `TEMLO_ADDR_MASK, 8'h00);
    rd_chk("force reg", `TEMLO_ADDR_FORCE, 8'h00);
  endtask

  task automatic t_power();
    temlo_host_model_inst.set_standby();
    #1;
    check("power_down", 8'(pd), 8'h40);
    check("standby", 8'(standby), 8'h01);
    temlo_host_model_inst.set_normal();
    #1;
    check("power_down", 8'(pd), 8'h3F);
    check("standby", 8'(standby), 8'h00);
    temlo_host_model_inst.chan_reset();
    #1;
    check("channel_reset", 8'(chan_rst), 8'h01);
    tick(1);
    check("channel_reset", 8'(chan_rst), 8'h00);
    rd_chk("power reg", `TEMLO_ADDR_POWER, 8'h3F);
  endtask

  task automatic t_events();
    for (int i = 0; i < 5; i++) begin
      temlo_host_model_inst.chan_reset();
      tick(2);
      temlo_host_model_inst.write_reg(`TEMLO_ADDR_MASK, 8'h00);
      pulse(5'(1 << i), 3);
      check("count", counts[i], 8'h03);
      temlo_host_model_inst.write_reg(`TEMLO_ADDR_MASK, 8'(1 << i));
      pulse(5'h1F, 2);
      check("masked count", counts[i], 8'h03);
      check("other count", counts[(i + 1) % 5], 8'h02);
      rd_chk("mask reg", `TEMLO_ADDR_MASK, 8'(1 << i));
    end
    temlo_host_model_inst.chan_reset();
    tick(2);
    check("cleared count", counts[0], 8'h00);
  endtask

  task automatic t_force();
    @(posedge clk_in);
    raw <= 1'b1;
    tick(4);
    check("indicator", 8'(ind), 8'h01);
    frc(`TEMLO_ADDR_FORCE, 8'h02, 1'b0);
    frc(`TEMLO_ADDR_FORCE, 8'h03, 1'b1);
    rd_chk("force reg", `TEMLO_ADDR_FORCE, 8'h03);
    @(posedge clk_in);
    raw <= 1'b0;
    tick(4);
    check("indicator", 8'(ind), 8'h01);
    frc(`TEMLO_ADDR_FORCE, 8'h01, 1'b1);
    frc(`TEMLO_ADDR_FORCE, 8'h00, 1'b0);
    frc(8'h29, 8'h03, 1'b0);
    rd_chk("unmapped reg", 8'h29, 8'h00);
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    tick(1);
    t_reset();
    t_power();
    t_events();
    t_force();
    close_out();
  end
endmodule

`default_nettype wire
